// ---- verilog/mcrc_top.sv ----
// Memory CRC checker: APB registers, scan/transfer/verify/fill engine
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
module mcrc_top (
    // Clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   rstn_in,
    // APB slave
    input  wire mcrc_pkg::mcrc_apb_req_t apb_in,
    output logic                 [31:0] prdata_out,
    output logic                        pready_out,
    output logic                        pslverr_out,
    // Source channel stream
    input  wire logic                   src_valid_in,
    input  wire logic            [31:0] src_data_in,
    output logic                        src_ready_out,
    // Destination channel stream
    output logic                        dst_valid_out,
    output logic                 [31:0] dst_data_out,
    output logic                        dst_last_out,
    input  wire logic                   dst_ready_in,
    // Events
    output logic                        irq_out,
    output logic                        fault_irq_out,
    output logic                        err_irq_out,
    output logic                        fault_trig_out
);
    mcrc_pkg::mcrc_state_t r;       // Registered state
    mcrc_pkg::mcrc_state_t next_r;  // Next state

    logic [31:0] bit_rev;   // Bits reversed inside each byte
    logic [31:0] byte_rev;  // Bytes swapped
    logic [31:0] mir_data;  // Word as fed to the CRC
    logic [31:0] pre_swap;  // After bit mirror
    logic [31:0] crc_nxt;   // Signature after this word
    logic        acc;       // APB access phase
    logic        wr_fire;   // Write completes this edge
    logic        hit;       // Address mapped
    logic [31:0] rd;        // Read mux
    logic [3:0]  set;       // Status events this cycle
    logic [3:0]  clr;       // Status bits software clears
    logic        start;     // Start request
    logic        accept;    // Source word taken
    logic        beat;      // One block word processed
    logic        last;      // Final word of block

    // Mirroring per bit; one loop builds both reorderings
    for (genvar i = 0; i < 32; i++) begin : g_mir
        assign bit_rev[i]  = src_data_in[(i / 8) * 8 + 7 - (i % 8)];
        assign byte_rev[i] = pre_swap[(3 - i / 8) * 8 + (i % 8)];
    end
    // Byte swap acts on the bit-mirrored word
    assign pre_swap = r.bitmir ? bit_rev : src_data_in;
    assign mir_data = r.bytmir ? byte_rev : pre_swap;

    // Single-word CRC step with the programmed polynomial
    mcrc_step u_step (
        .crc_in  (r.crc),
        .data_in (mir_data),
        .poly_in (r.poly),
        .crc_out (crc_nxt)
    );

    // Next-state logic for bus, engine and events
    always_comb begin
        next_r  = r;
        next_r.trig = 1'b0;
        set     = 4'h0;
        clr     = 4'h0;
        start   = 1'b0;
        beat    = 1'b0;
        last    = (r.xleft == 16'h0001) && (r.yleft == 16'h0001);
        acc     = apb_in.psel && apb_in.penable;
        wr_fire = acc && r.pready && apb_in.pwrite;
        accept  = src_valid_in && r.src_rdy;
        hit     = 1'b1;
        // Read mux; unmapped reads return zero with an error
        case (apb_in.paddr)
            mcrc_pkg::CTRL_OFS:   rd = {26'h0, r.route, r.bytmir, r.bitmir, r.mode, 1'b0};
            mcrc_pkg::POLY_OFS:   rd = r.poly;
            mcrc_pkg::SEED_OFS:   rd = r.seed;
            mcrc_pkg::EXPECT_OFS: rd = r.expect_val;
            mcrc_pkg::FILL_OFS:   rd = r.fill;
            mcrc_pkg::XCNT_OFS:   rd = {16'h0, r.xcnt};
            mcrc_pkg::YCNT_OFS:   rd = {16'h0, r.ycnt};
            mcrc_pkg::RESULT_OFS: rd = r.crc;
            mcrc_pkg::STATUS_OFS: rd = {27'h0, r.st != mcrc_pkg::ST_IDLE, r.status};
            mcrc_pkg::MASK_OFS:   rd = {28'h0, r.mask};
            default: begin
                rd  = 32'h00000000;
                hit = 1'b0;
            end
        endcase
        // One wait state: answer is registered in the first access cycle
        next_r.pready = acc && !r.pready;
        if (acc && !r.pready) begin
            next_r.prdata  = apb_in.pwrite ? 32'h00000000 : rd;
            next_r.pslverr = !hit;
        end else if (!acc) begin
            next_r.pslverr = 1'b0;
        end
        // Register writes take effect at the completing edge
        if (wr_fire) begin
            case (apb_in.paddr)
                mcrc_pkg::CTRL_OFS: begin
                    start = apb_in.pwdata[mcrc_pkg::CTRL_START_BIT];
                    // Mode changes mid-block would corrupt it, so idle only
                    if (r.st == mcrc_pkg::ST_IDLE) begin
                        next_r.mode   = mcrc_pkg::mcrc_mode_t'(
                            apb_in.pwdata[mcrc_pkg::CTRL_MODE_LSB +: 2]);
                        next_r.bitmir = apb_in.pwdata[mcrc_pkg::CTRL_BITMIR_BIT];
                        next_r.bytmir = apb_in.pwdata[mcrc_pkg::CTRL_BYTMIR_BIT];
                        next_r.route  = apb_in.pwdata[mcrc_pkg::CTRL_ROUTE_BIT];
                    end
                end
                mcrc_pkg::POLY_OFS:   next_r.poly = apb_in.pwdata;
                mcrc_pkg::SEED_OFS:   next_r.seed = apb_in.pwdata;
                mcrc_pkg::EXPECT_OFS: next_r.expect_val = apb_in.pwdata;
                mcrc_pkg::FILL_OFS:   next_r.fill = apb_in.pwdata;
                mcrc_pkg::XCNT_OFS:   next_r.xcnt = apb_in.pwdata[15:0];
                mcrc_pkg::YCNT_OFS:   next_r.ycnt = apb_in.pwdata[15:0];
                mcrc_pkg::STATUS_OFS: clr = apb_in.pwdata[3:0];
                mcrc_pkg::MASK_OFS:   next_r.mask = apb_in.pwdata[3:0];
                default: begin
                end
            endcase
        end
        // Destination register empties when the channel takes it
        if (r.dst_valid && dst_ready_in) begin
            next_r.dst_valid = 1'b0;
        end
        // Engine sequencer
        case (r.st)
            mcrc_pkg::ST_IDLE: begin
                if (start) begin
                    next_r.crc       = r.seed;
                    next_r.xleft     = r.xcnt;
                    next_r.yleft     = (r.ycnt == 16'h0000) ? 16'h0001 : r.ycnt;
                    next_r.verr_seen = 1'b0;
                    // Empty block goes straight to the check
                    next_r.st = (r.xcnt == 16'h0000) ? mcrc_pkg::ST_CHECK
                                                     : mcrc_pkg::ST_RUN;
                end
            end
            mcrc_pkg::ST_RUN: begin
                // Fill paces on the destination, others on the source
                beat = (r.mode == mcrc_pkg::MCRC_FILL)
                     ? (!r.dst_valid || dst_ready_in) : accept;
                if (beat) begin
                    if (r.mode != mcrc_pkg::MCRC_FILL) begin
                        next_r.crc = crc_nxt;
                    end
                    if (r.mode == mcrc_pkg::MCRC_XFER) begin
                        next_r.dst_valid = 1'b1;
                        next_r.dst_data  = src_data_in;
                        next_r.dst_last  = r.xleft == 16'h0001;
                    end
                    if (r.mode == mcrc_pkg::MCRC_FILL) begin
                        next_r.dst_valid = 1'b1;
                        next_r.dst_data  = r.fill;
                        next_r.dst_last  = r.xleft == 16'h0001;
                    end
                    // Only the first bad word is reported per block
                    if (r.mode == mcrc_pkg::MCRC_VERIFY && src_data_in != r.fill
                        && !r.verr_seen) begin
                        set[mcrc_pkg::STAT_VERR_BIT] = 1'b1;
                        next_r.verr_seen = 1'b1;
                    end
                    // Row and column counters walk the 2D block
                    if (last) begin
                        next_r.st = mcrc_pkg::ST_DRAIN;
                    end else if (r.xleft == 16'h0001) begin
                        next_r.xleft = r.xcnt;
                        next_r.yleft = r.yleft - 16'h0001;
                    end else begin
                        next_r.xleft = r.xleft - 16'h0001;
                    end
                end
            end
            mcrc_pkg::ST_DRAIN: begin
                // Wait for the last forwarded word to leave
                if (!next_r.dst_valid) begin
                    next_r.st = mcrc_pkg::ST_CHECK;
                end
            end
            mcrc_pkg::ST_CHECK: begin
                set[mcrc_pkg::STAT_DONE_BIT] = 1'b1;
                if (r.mode != mcrc_pkg::MCRC_FILL && r.crc != r.expect_val) begin
                    set[mcrc_pkg::STAT_FAULT_BIT] = 1'b1;
                    next_r.trig = r.route;
                end
                next_r.st = mcrc_pkg::ST_IDLE;
            end
            default: next_r.st = mcrc_pkg::ST_IDLE;
        endcase
        // Starting a busy engine is an operating error
        if (start && r.st != mcrc_pkg::ST_IDLE) begin
            set[mcrc_pkg::STAT_BERR_BIT] = 1'b1;
        end
        // Source ready registered; transfer waits for an empty slot
        next_r.src_rdy = (next_r.st == mcrc_pkg::ST_RUN)
                      && (r.mode != mcrc_pkg::MCRC_FILL)
                      && (r.mode != mcrc_pkg::MCRC_XFER || !next_r.dst_valid);
        // Sticky status: a new event wins over a clear
        next_r.status = (r.status & ~clr) | set;
        // Interrupt levels from the updated status and mask
        next_r.irq       = |(next_r.status & next_r.mask);
        next_r.fault_irq = next_r.status[mcrc_pkg::STAT_FAULT_BIT]
                         && next_r.mask[mcrc_pkg::STAT_FAULT_BIT]
                         && !next_r.route;
        next_r.err_irq   = |(next_r.status[3:2] & next_r.mask[3:2]);
    end

    // State register
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r            <= '0;
            r.st         <= mcrc_pkg::ST_IDLE;
            r.mode       <= mcrc_pkg::MCRC_SCAN;
            r.poly       <= mcrc_pkg::POLY_RST;
            r.seed       <= mcrc_pkg::SEED_RST;
            r.expect_val <= mcrc_pkg::WORD_RST;
            r.fill       <= mcrc_pkg::WORD_RST;
            r.xcnt       <= mcrc_pkg::CNT_RST;
            r.ycnt       <= mcrc_pkg::CNT_RST;
            r.crc        <= mcrc_pkg::SEED_RST;
            r.status     <= mcrc_pkg::STAT_RST;
            r.mask       <= mcrc_pkg::MASK_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign prdata_out     = r.prdata;
    assign pready_out     = r.pready;
    assign pslverr_out    = r.pslverr;
    assign src_ready_out  = r.src_rdy;
    assign dst_valid_out  = r.dst_valid;
    assign dst_data_out   = r.dst_data;
    assign dst_last_out   = r.dst_last;
    assign irq_out        = r.irq;
    assign fault_irq_out  = r.fault_irq;
    assign err_irq_out    = r.err_irq;
    assign fault_trig_out = r.trig;

    // Each accepted word folds into the signature
    a_crc_word_update: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (r.st == mcrc_pkg::ST_RUN && accept && r.mode != mcrc_pkg::MCRC_FILL)
        |=> (r.crc == $past(crc_nxt)))
        else $error("signature not updated by word");

    // Signature holds when no word arrives
    a_crc_word_hold: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (r.st == mcrc_pkg::ST_RUN && !accept) |=> $stable(r.crc))
        else $error("signature changed without a word");

    // Scan mode never writes to the destination
    a_scan_no_write: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (r.mode == mcrc_pkg::MCRC_SCAN && r.st != mcrc_pkg::ST_IDLE) |-> !dst_valid_out)
        else $error("scan mode produced a write");

    // Transfer forwards the accepted word next cycle
    a_xfer_forward: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (r.st == mcrc_pkg::ST_RUN && accept && r.mode == mcrc_pkg::MCRC_XFER)
        |=> dst_valid_out && dst_data_out == $past(src_data_in))
        else $error("transfer word not forwarded");

    // Mismatch at check sets fault and the fault level on the same next edge
    a_fault_on_diff: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (r.st == mcrc_pkg::ST_CHECK && r.mode != mcrc_pkg::MCRC_FILL
         && r.crc != r.expect_val && r.mask[1] && !r.route)
        |=> r.status[mcrc_pkg::STAT_FAULT_BIT] && fault_irq_out && irq_out)
        else $error("mismatch did not raise fault");

    // Trigger route gives a single-cycle pulse
    a_fault_trig: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (r.st == mcrc_pkg::ST_CHECK && r.mode != mcrc_pkg::MCRC_FILL
         && r.crc != r.expect_val && r.route)
        |=> fault_trig_out ##1 !fault_trig_out)
        else $error("fault trigger pulse wrong");

    // Fill words carry the constant
    a_fill_const: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (dst_valid_out && r.mode == mcrc_pkg::MCRC_FILL) |-> dst_data_out == r.fill)
        else $error("fill word is not the constant");

    // First verify mismatch sets the error flag and error level
    a_verify_first: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (r.st == mcrc_pkg::ST_RUN && accept && r.mode == mcrc_pkg::MCRC_VERIFY
         && src_data_in != r.fill && r.mask[2])
        |=> r.status[mcrc_pkg::STAT_VERR_BIT] && err_irq_out)
        else $error("verify mismatch not flagged");

    // Start loads the seed into the signature
    a_seed_load: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (r.st == mcrc_pkg::ST_IDLE && wr_fire && apb_in.paddr == mcrc_pkg::CTRL_OFS
         && apb_in.pwdata[0]) |=> r.crc == $past(r.seed) && r.st != mcrc_pkg::ST_IDLE)
        else $error("seed not loaded at start");

    // Busy start: error set, mode kept
    a_busy_start: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (r.st != mcrc_pkg::ST_IDLE && start)
        |=> r.status[mcrc_pkg::STAT_BERR_BIT] && $stable(r.mode))
        else $error("start while busy not refused");

    // Idle refuses source
    a_src_idle: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (r.st == mcrc_pkg::ST_IDLE) |-> !src_ready_out)
        else $error("source ready while idle");

    // APB answers exactly one cycle into the access phase
    a_apb_one_wait: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (apb_in.psel && apb_in.penable && !pready_out) |=> pready_out)
        else $error("APB answer late");
endmodule

// ---- verilog/mcrc_pkg.sv ----
// Constants, enumerations and carrier types for the memory CRC checker
package mcrc_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] POLY_OFS   = 8'h04;
    localparam logic [7:0] SEED_OFS   = 8'h08;
    localparam logic [7:0] EXPECT_OFS = 8'h0c;
    localparam logic [7:0] FILL_OFS   = 8'h10;
    localparam logic [7:0] XCNT_OFS   = 8'h14;
    localparam logic [7:0] YCNT_OFS   = 8'h18;
    localparam logic [7:0] RESULT_OFS = 8'h1c;
    localparam logic [7:0] STATUS_OFS = 8'h20;
    localparam logic [7:0] MASK_OFS   = 8'h24;

    // Control field positions
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_MODE_LSB   = 1;
    localparam int CTRL_BITMIR_BIT = 3;
    localparam int CTRL_BYTMIR_BIT = 4;
    localparam int CTRL_ROUTE_BIT  = 5;

    // Status field positions
    localparam int STAT_DONE_BIT  = 0;
    localparam int STAT_FAULT_BIT = 1;
    localparam int STAT_VERR_BIT  = 2;
    localparam int STAT_BERR_BIT  = 3;
    localparam int STAT_BUSY_BIT  = 4;

    // Reset values
    localparam logic [31:0] POLY_RST = 32'h04c11db7;
    localparam logic [31:0] SEED_RST = 32'hffffffff;
    localparam logic [31:0] WORD_RST = 32'h00000000;
    localparam logic [15:0] CNT_RST  = 16'h0001;
    localparam logic [3:0]  STAT_RST = 4'h0;
    localparam logic [3:0]  MASK_RST = 4'h0;

    // Operating modes
    typedef enum logic [1:0] {
        MCRC_SCAN   = 2'h0,
        MCRC_XFER   = 2'h1,
        MCRC_VERIFY = 2'h2,
        MCRC_FILL   = 2'h3
    } mcrc_mode_t;

    // Engine sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_RUN   = 2'h1,
        ST_DRAIN = 2'h2,
        ST_CHECK = 2'h3
    } mcrc_fsm_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } mcrc_apb_req_t;

    // Whole state of the top module
    typedef struct packed {
        mcrc_fsm_t   st;
        mcrc_mode_t  mode;
        logic        bitmir;
        logic        bytmir;
        logic        route;
        logic [31:0] poly;
        logic [31:0] seed;
        logic [31:0] expect_val;
        logic [31:0] fill;
        logic [15:0] xcnt;
        logic [15:0] ycnt;
        logic [15:0] xleft;
        logic [15:0] yleft;
        logic [31:0] crc;
        logic        verr_seen;
        logic [3:0]  status;
        logic [3:0]  mask;
        logic        src_rdy;
        logic        dst_valid;
        logic [31:0] dst_data;
        logic        dst_last;
        logic        irq;
        logic        fault_irq;
        logic        err_irq;
        logic        trig;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } mcrc_state_t;
endpackage

// ---- verilog/mcrc_step.sv ----
// One-word CRC32 update with a programmable generator polynomial
`timescale 1ns/100ps
module mcrc_step (
    // Running signature and new word
    input  wire logic [31:0] crc_in,
    input  wire logic [31:0] data_in,
    input  wire logic [31:0] poly_in,
    // Updated signature
    output logic      [31:0] crc_out
);
    // Shift the word in MSB first; feedback xors the polynomial
    always_comb begin
        logic [31:0] c;
        logic        fb;
        c  = crc_in;
        fb = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            fb = c[31] ^ data_in[i];
            c  = {c[30:0], 1'b0} ^ (fb ? poly_in : 32'h00000000);
        end
        crc_out = c;
    end
endmodule

// ---- verification/mcrc_dma_model.sv ----
// Source and destination DMA channel model facing the CRC engine
`timescale 1ns/100ps
module mcrc_dma_model (
    // Clock, reset and pacing from the bench
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        run_in,
    input  wire logic        slow_in,
    input  wire logic [15:0] limit_in,
    input  wire logic [31:0] word_in,
    output logic      [15:0] count_out,
    // Source channel
    output logic             src_valid_out,
    output logic      [31:0] src_data_out,
    input  wire logic        src_ready_in,
    // Destination channel
    output logic             dst_ready_out
);
    logic ph; // Toggles each cycle to pace slow traffic

    // Offer words in block order; each offer is held until taken
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {ph, count_out, src_valid_out, src_data_out, dst_ready_out} <= '0;
        end else begin
            ph            <= ~ph;
            dst_ready_out <= !slow_in || ph; // Stalls half the time when slow
            if (src_valid_out && !src_ready_in) begin
                // Hold word and valid until the engine takes it
            end else if (run_in && count_out < limit_in && (!slow_in || ph)) begin
                src_valid_out <= 1'b1;
                src_data_out  <= word_in;
                count_out     <= count_out + 16'h0001;
            end else begin
                // Released: data toggles, so it cannot look fresh
                src_valid_out <= 1'b0;
                src_data_out  <= ~src_data_out;
                if (!run_in) begin
                    count_out <= 16'h0000;
                end
            end
        end
    end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the memory CRC checker
`timescale 1ns/100ps
module tb_top;
    logic                    core_clk_in = 1'b0; // 20 MHz clock
    logic                    rstn_in     = 1'b0; // Held low at start
    mcrc_pkg::mcrc_apb_req_t apb         = '0;   // APB request
    logic [31:0] prdata, src_data, dst_data;
    logic        pready, pslverr, src_valid, src_ready, dst_valid, dst_last, dst_ready;
    logic        irq, fault_irq, err_irq, trig;
    logic        run   = 1'b0;         // Lets the model offer words
    logic        slow  = 1'b0;         // Model stalls every other cycle
    logic [15:0] limit = '0;           // Words in the current block
    logic [15:0] cnt;                  // Words offered so far
    logic [31:0] wbuf [0:63];          // Words of the current block
    logic [31:0] rng   = 32'h00000041; // xorshift state, starts at 65
    logic [32:0] dq [$];               // Expected destination words, last flag on top
    int          fail_count = 0;
    int          cmp_count  = 0;
    int          trig_seen  = 0;
    int          trig_exp   = 0;

    // Half period of 25 ns
    always #25 core_clk_in = ~core_clk_in;

    mcrc_top mcrc_top_inst (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in), .apb_in(apb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .src_valid_in(src_valid), .src_data_in(src_data), .src_ready_out(src_ready),
        .dst_valid_out(dst_valid), .dst_data_out(dst_data), .dst_last_out(dst_last),
        .dst_ready_in(dst_ready), .irq_out(irq), .fault_irq_out(fault_irq),
        .err_irq_out(err_irq), .fault_trig_out(trig));

    mcrc_dma_model mcrc_dma_model_inst (
        .clk_in(core_clk_in), .rstn_in(rstn_in), .run_in(run), .slow_in(slow),
        .limit_in(limit), .word_in(wbuf[cnt[5:0]]), .count_out(cnt),
        .src_valid_out(src_valid), .src_data_out(src_data), .src_ready_in(src_ready),
        .dst_ready_out(dst_ready));

    // Next pseudo-random word
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // Reference signature step: MSB first, no reflection
    function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d,
                                             input logic [31:0] p);
        for (int i = 31; i >= 0; i--) begin
            c = (c[31] ^ d[i]) ? ((c << 1) ^ p) : (c << 1);
        end
        return c;
    endfunction

    // Optional bit reversal within bytes, then optional byte swap
    function automatic logic [31:0] mirror(input logic [31:0] d, input logic bm, input logic ym);
        logic [31:0] r;
        r = d;
        for (int i = 0; i < 32; i++) begin
            if (bm) r[i] = d[(i & ~7) + 7 - (i & 7)];
        end
        return ym ? {r[7:0], r[15:8], r[23:16], r[31:24]} : r;
    endfunction

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One APB transfer; entered right after a rising edge
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q, output logic e);
        int n;
        n = 0;
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge core_clk_in);
        apb.penable <= 1'b1;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            stop_test();
        end
        q = prdata;
        e = pslverr;
        apb <= '0;
        // Idle edge between two requests
        @(posedge core_clk_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb_xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] q;
        logic        e;
        apb_xfer(1'b0, a, 32'h0, q, e);
        chk_val(q, exp);
        chk_val({31'h0, e}, {31'h0, eexp});
    endtask

    // Destination words against the queue; trigger pulses counted
    always @(posedge core_clk_in) begin
        logic [32:0] x;
        if (rstn_in && dst_valid && dst_ready) begin
            x = (dq.size() > 0) ? dq.pop_front() : 33'h1ffffffff;
            chk_val(dst_data, x[31:0]);
            chk_val({31'h0, dst_last}, {31'h0, x[32]});
        end
        if (rstn_in && trig === 1'b1) trig_seen++;
    end

    // One block in any mode; good selects a matching expected signature
    task automatic run_block(input mcrc_pkg::mcrc_mode_t md, input logic bm, input logic ym,
                             input logic rt, input int xc, input int yc, input logic good,
                             input logic poke, input logic sl);
        int          nw;
        int          n;
        logic [31:0] c, p, f, s, q;
        logic        e, flt, verr;
        nw = xc * ((yc == 0) ? 1 : yc);
        p = rnd();
        f = rnd();
        s = rnd();
        c = s;
        verr = (md == mcrc_pkg::MCRC_VERIFY);
        flt = !good && md != mcrc_pkg::MCRC_FILL;
        for (int i = 0; i < nw; i++) begin
            wbuf[i] = (verr && i != 2) ? f : rnd();
            c = crc_word(c, mirror(wbuf[i], bm, ym), p);
            if (md != mcrc_pkg::MCRC_SCAN && md != mcrc_pkg::MCRC_VERIFY) begin
                dq.push_back({i % xc == xc - 1, (md == mcrc_pkg::MCRC_FILL) ? f : wbuf[i]});
            end
        end
        trig_exp += (flt && rt) ? 1 : 0;
        wr(mcrc_pkg::POLY_OFS, p);
        wr(mcrc_pkg::SEED_OFS, s);
        wr(mcrc_pkg::EXPECT_OFS, good ? c : ~c);
        wr(mcrc_pkg::FILL_OFS, f);
        wr(mcrc_pkg::XCNT_OFS, 32'(xc));
        wr(mcrc_pkg::YCNT_OFS, 32'(yc));
        slow  <= sl;
        limit <= (md == mcrc_pkg::MCRC_FILL) ? 16'h0000 : 16'(nw);
        wr(mcrc_pkg::CTRL_OFS, {26'h0, rt, ym, bm, md, 1'b1});
        run <= 1'b1;
        if (poke) wr(mcrc_pkg::CTRL_OFS, {26'h0, rt, ym, bm, md, 1'b1});
        n = 0;
        do begin
            apb_xfer(1'b0, mcrc_pkg::STATUS_OFS, 32'h0, q, e);
            n++;
        end while (q[0] !== 1'b1 && n < 100);
        if (n >= 100) begin
            fail_count++;
            stop_test();
        end
        chk_val({27'h0, q[4:0]}, {27'h0, 1'b0, poke, verr, flt, 1'b1});
        chk_val(32'(dq.size()), 32'h0);
        if (md != mcrc_pkg::MCRC_FILL) rd_chk(mcrc_pkg::RESULT_OFS, c, 1'b0);
        @(negedge core_clk_in);
        chk_val({29'h0, irq, fault_irq, err_irq}, {29'h0, 1'b1, flt & !rt, verr | poke});
        chk_val({30'h0, src_ready, dst_valid}, 32'h0);
        chk_val(32'(trig_seen), 32'(trig_exp));
        @(posedge core_clk_in);
        wr(mcrc_pkg::STATUS_OFS, 32'h0000000f);
        run <= 1'b0;
        rd_chk(mcrc_pkg::STATUS_OFS, 32'h0, 1'b0);
        @(negedge core_clk_in);
        chk_val({31'h0, irq}, 32'h0);
        @(posedge core_clk_in);
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        @(posedge core_clk_in);
        rd_chk(mcrc_pkg::POLY_OFS, 32'h04c11db7, 1'b0);
        rd_chk(mcrc_pkg::SEED_OFS, 32'hffffffff, 1'b0);
        rd_chk(mcrc_pkg::YCNT_OFS, 32'h00000001, 1'b0);
        rd_chk(8'h28, 32'h0, 1'b1);
        wr(mcrc_pkg::MASK_OFS, 32'h0000000f);
        rd_chk(mcrc_pkg::MASK_OFS, 32'h0000000f, 1'b0);
        // Every mirror setting, both routes, good and bad signatures
        for (int m = 0; m < 4; m++) begin
            run_block(mcrc_pkg::MCRC_SCAN, m[0], m[1], m[0], 3, 2, m[1], 0, m[0]);
        end
        run_block(mcrc_pkg::MCRC_XFER, 0, 0, 1, 4, 2, 0, 0, 1);
        run_block(mcrc_pkg::MCRC_VERIFY, 0, 0, 0, 5, 0, 1, 0, 0);
        run_block(mcrc_pkg::MCRC_FILL, 0, 0, 0, 2, 2, 1, 0, 1);
        run_block(mcrc_pkg::MCRC_SCAN, 0, 0, 0, 3, 3, 1, 1, 1);
        stop_test();
    end
endmodule
